// *** verilog/sac_pkg.sv ***
/*
 sac_pkg: constants, register map, field positions and carrier structs for the
 converter control block.
 Assumes a single 100 MHz clock domain and an AXI4-Lite register master.
*/
// Functional notes
// R1 - convert start low begins a conversion
// R2 - bit decisions done, form code, busy low
// R3 - ignore start and power-down while converting
// R4 - start not gated by select or read
// R5 - held start low repeats conversions automatically
// R6 - host pulses start once after power-up
// R7 - free-running rate may exceed 100 kSPS
// R8 - outputs drive only when select and read low
// R9 - coding select works except 18-bit mode
// R10 - 18-bit code, midscale and saturation values
// R11 - parallel bus 18, 16 or 8 bits
// R12 - result readable in acquisition or next conversion
// R13 - host reads in first conversion half
// R14 - both mode inputs high select serial
// R15 - serial sends 18 bits msb first
// R16 - serial bit stable across both clock edges
// R17 - clock source low makes device master
// R18 - master drives frame strobe, polarities invertible
// R19 - read-timing select: after or during conversion
// R20 - read-after mode holds busy until shifted
// R21 - read-during shifts only in first half
// R22 - divider inputs slow the serial clock
// R23 - reduced power after every conversion phase
// R24 - reference buffer power-down input controls buffer
// R25 - busy high from start until result ready
package sac_pkg;

    localparam int unsigned  CLK_HZ          = 100_000_000;
    localparam int unsigned  RES_BITS        = 18;
    localparam int unsigned  CONV_TIME_NS    = 7000;
    localparam int unsigned  ACQ_TIME_NS     = 2000;
    localparam int unsigned  CONV_CYC        = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned  ACQ_CYC         = (ACQ_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned  BIT_CYC         = CONV_CYC / RES_BITS;
    localparam int unsigned  HALF_CONV_CYC   = CONV_CYC / 2;

    localparam logic [17:0]  CODE_MID_BIN    = 18'h20000;
    localparam logic [17:0]  CODE_MAX_BIN    = 18'h3ffff;
    localparam logic [17:0]  CODE_MAX_TWOS   = 18'h1ffff;

    localparam logic [7:0]   OFS_CTRL        = 8'h00;
    localparam logic [7:0]   OFS_STATUS      = 8'h04;
    localparam logic [7:0]   OFS_RESULT      = 8'h08;
    localparam logic [7:0]   OFS_SAMPLE      = 8'h0c;

    localparam int unsigned  CTRL_START      = 0;
    localparam int unsigned  CTRL_PD         = 1;
    localparam int unsigned  CTRL_REF_BUFFER_POWER_DOWN      = 2;
    localparam int unsigned  CTRL_CODING     = 3;
    localparam int unsigned  CTRL_SEL0       = 4;
    localparam int unsigned  CTRL_SEL1       = 5;
    localparam int unsigned  CTRL_CLKSRC     = 6;
    localparam int unsigned  CTRL_RDTIME     = 7;
    localparam int unsigned  CTRL_INV_SCLK   = 8;
    localparam int unsigned  CTRL_INV_SYNC   = 9;
    localparam int unsigned  CTRL_DIV_LSB    = 10;
    localparam logic [11:0]  CTRL_RESET      = 12'h0c1;

    localparam logic [1:0]   RESP_OKAY       = 2'b00;
    localparam logic [1:0]   RESP_SLVERR     = 2'b10;

    typedef struct packed {
        logic [1:0]  serial_clock_divider;
        logic        inv_sync;
        logic        inv_sclk;
        logic        read_timing_select;
        logic        clock_source_select;
        logic        iface_sel1;
        logic        iface_sel0;
        logic        coding_select;
        logic        ref_buffer_power_down;
        logic        power_down_input;
        logic        convert_start_n;
    } sac_ctrl_t;

    typedef struct packed {
        logic [17:0] data;
        logic [17:0] data_oe;
    } sac_bus_t;

endpackage

// *** verilog/sac_serial.sv ***
/*
 sac_serial: master serial shifter, 18 bits msb first with frame strobe.
 Assumes load pulses from the control core on the same clock.
*/
`timescale 1ns/10ps
module sac_serial
    import sac_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        load,
    input  wire logic [17:0] word,
    input  wire logic [1:0]  div,
    input  wire logic        inv_sclk,
    input  wire logic        inv_sync,
    output logic             sclk,
    output logic             sync,
    output logic             sdata,
    output logic             active
);

    logic [17:0] shreg;
    logic [4:0]  bits_left;
    logic [4:0]  div_cnt;
    logic        phase;
    logic [4:0]  div_max;

    // divider inputs lengthen each half clock
    always_comb
    begin
        div_max = 5'((5'd1 << div) - 5'd1); // R22
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shreg     <= 18'h00000;
            bits_left <= 5'd0;
            div_cnt   <= 5'd0;
            phase     <= 1'b0;
        end
        else if (load && !active)
        begin
            shreg     <= word;
            bits_left <= 5'(RES_BITS);
            div_cnt   <= 5'd0;
            phase     <= 1'b0;
        end
        else if (active)
        begin
            if (div_cnt == div_max)
            begin
                div_cnt <= 5'd0;
                phase   <= ~phase;
                // data changes only after the falling half, stable over both edges
                if (phase)
                begin
                    shreg     <= {shreg[16:0], 1'b0}; // R15 R16
                    bits_left <= bits_left - 5'd1;
                end
            end
            else
            begin
                div_cnt <= div_cnt + 5'd1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sclk   <= 1'b0;
            sync   <= 1'b0;
            sdata  <= 1'b0;
            active <= 1'b0;
        end
        else
        begin
            active <= (load && !active) ||
                      ((bits_left != 5'd0) && !(bits_left == 5'd1 && phase && div_cnt == div_max));
            sclk   <= (phase & (bits_left != 5'd0)) ^ inv_sclk; // R18
            sync   <= (bits_left != 5'd0) ^ inv_sync; // R18
            sdata  <= shreg[17];
        end
    end

endmodule

// *** verilog/sac_core.sv ***
/*
 sac_core: conversion sequencing, result coding, parallel/serial output port
 and AXI4-Lite registers for an 18-bit successive-approximation converter.
 Assumes comparator decisions arrive synchronously, pins pass two flops here,
 and a pad ring resolves data_oe into tri-state pins.
*/
`timescale 1ns/10ps
module sac_core
    import sac_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        convert_start_n,
    input  wire logic        select_n,
    input  wire logic        read_n,
    input  wire logic        comparator,
    output logic             busy,
    output logic             low_power,
    output logic             ref_buffer_enable,
    output sac_bus_t         dbus
);

    typedef enum {ST_IDLE, ST_CONV, ST_SHIFT, ST_ACQ} sac_state_t;

    sac_state_t  state;
    sac_ctrl_t   ctrl;
    logic [1:0]  start_sync;
    logic [1:0]  sel_sync;
    logic [1:0]  rd_sync;
    logic [1:0]  cmp_sync;
    logic        start_prev;
    logic [15:0] cnt;
    logic [4:0]  bit_idx;
    logic [17:0] sar;
    logic [17:0] result;
    logic [17:0] prev_result;
    logic        start_n;
    logic        start_fall;
    logic        serial_mode;
    logic        master;
    logic        ser_load;
    logic [17:0] ser_word;
    logic        ser_sclk;
    logic        ser_sync;
    logic        ser_sdata;
    logic        ser_active;
    logic [17:0] coded;
    logic [17:0] next_data;
    logic [17:0] next_oe;
    logic        aw_hold;
    logic        w_hold;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [31:0] ctrl_word;
    logic        hi_byte;
    logic [15:0] sample_cnt;

    // pin inputs through two flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            start_sync <= 2'b11;
            sel_sync   <= 2'b11;
            rd_sync    <= 2'b11;
            cmp_sync   <= 2'b00;
        end
        else
        begin
            start_sync <= {start_sync[0], convert_start_n};
            sel_sync   <= {sel_sync[0], select_n};
            rd_sync    <= {rd_sync[0], read_n};
            cmp_sync   <= {cmp_sync[0], comparator};
        end
    end

    // pin and software start combine; select and read play no part
    assign start_n     = start_sync[1] & ctrl.convert_start_n; // R4
    assign start_fall  = start_prev & ~start_n; // R1
    assign serial_mode = ctrl.iface_sel0 & ctrl.iface_sel1; // R14
    assign master      = serial_mode & ~ctrl.clock_source_select; // R17

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            start_prev <= 1'b1;
        end
        else
        begin
            start_prev <= start_n;
        end
    end

    // conversion sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state       <= ST_IDLE;
            cnt         <= 16'h0000;
            bit_idx     <= 5'd0;
            sar         <= 18'h00000;
            result      <= 18'h00000;
            prev_result <= 18'h00000;
            busy        <= 1'b0;
            low_power   <= 1'b1;
            ser_load    <= 1'b0;
            ser_word    <= 18'h00000;
            sample_cnt  <= 16'h0000;
        end
        else
        begin
            ser_load <= 1'b0;
            case (state)
                ST_IDLE, ST_ACQ:
                begin
                    // held-low start times its own acquisition
                    if (state == ST_ACQ && cnt != 16'h0000)
                    begin
                        cnt <= cnt - 16'h0001;
                    end
                    if (start_fall || (state == ST_ACQ && !start_n && cnt == 16'h0000)) // R1 R5 R7
                    begin
                        state     <= ST_CONV;
                        busy      <= 1'b1; // R25
                        low_power <= 1'b0;
                        cnt       <= 16'(CONV_CYC - 1);
                        bit_idx   <= 5'd17;
                        sar       <= 18'h20000;
                        if (master && ctrl.read_timing_select)
                        begin
                            ser_load <= 1'b1; // R19 R21
                            ser_word <= coded;
                        end
                    end
                    else if (ctrl.power_down_input)
                    begin
                        state <= ST_IDLE;
                    end
                end
                ST_CONV:
                begin
                    // start and power-down are not looked at here
                    cnt <= cnt - 16'h0001; // R3
                    if (cnt % 16'(BIT_CYC) == 16'h0000 && bit_idx != 5'd31)
                    begin
                        if (!cmp_sync[1])
                        begin
                            sar[bit_idx] <= 1'b0;
                        end
                        if (bit_idx != 5'd0)
                        begin
                            sar[bit_idx - 5'd1] <= 1'b1;
                        end
                        bit_idx <= bit_idx - 5'd1;
                    end
                    if (cnt == 16'h0000)
                    begin
                        prev_result <= result;
                        result      <= sar; // R2 R10
                        low_power   <= 1'b1; // R23
                        sample_cnt  <= sample_cnt + 16'h0001;
                        cnt         <= 16'(ACQ_CYC);
                        if (master && !ctrl.read_timing_select)
                        begin
                            state    <= ST_SHIFT;
                            ser_load <= 1'b1;
                            ser_word <= ctrl.coding_select ? sar : (sar ^ CODE_MID_BIN);
                        end
                        else
                        begin
                            state <= ST_ACQ;
                            busy  <= 1'b0; // R2 R25
                        end
                    end
                end
                ST_SHIFT:
                begin
                    if (!ser_load && !ser_active)
                    begin
                        state <= ST_ACQ;
                        busy  <= 1'b0; // R20
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // straight binary when coding select high, twos complement when low; 18-bit parallel mode is always straight binary
    always_comb
    begin
        if (ctrl.iface_sel0 | ctrl.iface_sel1)
        begin
            coded = ctrl.coding_select ? result : (result ^ CODE_MID_BIN); // R9 R10
        end
        else
        begin
            coded = result;
        end
    end

    // parallel width and serial pin muxing
    always_comb
    begin
        next_data = 18'h00000;
        next_oe   = 18'h00000;
        if (serial_mode)
        begin
            next_data[2] = ser_sdata;
            next_data[3] = ser_sclk;
            next_data[4] = ser_sync;
            next_oe[2]   = 1'b1;
            next_oe[3]   = master;
            next_oe[4]   = master;
        end
        else if (ctrl.iface_sel1)
        begin
            next_data[7:0] = hi_byte ? coded[17:10] : {coded[9:2]}; // R11
            next_oe[7:0]   = 8'hff;
        end
        else if (ctrl.iface_sel0)
        begin
            next_data[15:0] = hi_byte ? {14'h0000, coded[1:0]} : coded[17:2]; // R11
            next_oe[15:0]   = 16'hffff;
        end
        else
        begin
            next_data = coded; // R11 R12
            next_oe   = 18'h3ffff;
        end
        if (sel_sync[1] | rd_sync[1])
        begin
            next_oe = 18'h00000; // R8
        end
    end

    // high byte or word chosen by the divider low bit in narrow modes
    assign hi_byte = ctrl.serial_clock_divider[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dbus              <= '0;
            ref_buffer_enable <= 1'b0;
        end
        else
        begin
            dbus.data         <= next_data;
            dbus.data_oe      <= next_oe;
            ref_buffer_enable <= ~ctrl.ref_buffer_power_down; // R24
        end
    end

    sac_serial u_serial (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (ser_load),
        .word     (ser_word),
        .div      (ctrl.serial_clock_divider),
        .inv_sclk (ctrl.inv_sclk),
        .inv_sync (ctrl.inv_sync),
        .sclk     (ser_sclk),
        .sync     (ser_sync),
        .sdata    (ser_sdata),
        .active   (ser_active)
    );

    // axi4-lite write channel
    assign ctrl_word = {20'h00000, ctrl};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            ctrl          <= sac_ctrl_t'(CTRL_RESET);
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_hold && w_hold && !s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                if (aw_addr[7:2] == OFS_CTRL[7:2])
                begin
                    s_axi_bresp <= RESP_OKAY;
                    if (w_strb[0])
                    begin
                        ctrl[7:0] <= w_data[7:0];
                    end
                    if (w_strb[1])
                    begin
                        ctrl[11:8] <= w_data[11:8];
                    end
                end
                else
                begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // axi4-lite read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            case (s_axi_araddr[7:2])
                OFS_CTRL[7:2]:   s_axi_rdata <= ctrl_word;
                OFS_STATUS[7:2]: s_axi_rdata <= {28'h0000000, ser_active, low_power, busy,
                                                 state == ST_CONV};
                OFS_RESULT[7:2]: s_axi_rdata <= {14'h0000, coded};
                OFS_SAMPLE[7:2]: s_axi_rdata <= {16'h0000, sample_cnt};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// *** verification/sac_core_asserts.sv ***
/*
 sac_core_asserts: port-level property checks for sac_core, bound below.
 Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/10ps
module sac_core_asserts
    import sac_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    input  wire logic        convert_start_n,
    input  wire logic        select_n,
    input  wire logic        read_n,
    input  wire logic        busy,
    input  wire logic        low_power,
    input  wire sac_bus_t    dbus
);
    logic [11:0] run;

    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            run <= 12'h000;
        else
            run <= busy ? run + 12'h001 : 12'h000;
    end

    chk_start_busy: assert property ($fell(convert_start_n) && !busy |-> ##[1:6] busy)
        else $error("busy did not follow start");
    chk_busy_width: assert property ($fell(busy) |-> run >= 12'd699)
        else $error("busy run shorter than a conversion");
    chk_lp_leave: assert property ($rose(busy) |-> ##[0:2] !low_power)
        else $error("low power kept during conversion");
    chk_lp_enter: assert property ($fell(busy) |-> ##[0:2] low_power)
        else $error("low power not entered after conversion");
    chk_hiz_idle: assert property ((select_n || read_n) [*5] |-> dbus.data_oe == 18'h00000)
        else $error("bus driven while deselected");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    chk_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0f
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    chk_write_hold: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
endmodule

bind sac_core sac_core_asserts u_chk (.*);

// *** verification/sac_host_model.sv ***
/*
 sac_host_model: far side of the converter; comparator source and serial receiver.
 Assumes serial data on bus bit 2, clock bit 3, frame strobe bit 4, active high.
*/
`timescale 1ns/10ps
module sac_host_model
    import sac_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        comp_level,
    input  wire logic        clear,
    input  wire sac_bus_t    dbus,
    output logic             comparator,
    output logic [17:0]      word,
    output logic [4:0]       bits,
    output logic             edge_err
);
    logic sclk_q;
    logic hi_bit;

    initial
    begin
        comparator = 1'b0;
        word = 18'h00000;
        bits = 5'h00;
        edge_err = 1'b0;
        sclk_q = 1'b0;
        hi_bit = 1'b0;
    end

    always @(posedge aclk)
    begin
        comparator <= comp_level;
        sclk_q <= dbus.data[3];
        if (dbus.data[3])
            hi_bit <= dbus.data[2];
        if (clear)
        begin
            bits <= 5'h00;
            edge_err <= 1'b0;
        end
        else if (dbus.data[4] && dbus.data[3] && !sclk_q)
        begin
            word <= {word[16:0], dbus.data[2]};
            bits <= bits + 5'h01;
        end
        // bit taken at rise must still stand at fall
        if (!clear && bits != 5'h00 && sclk_q && !dbus.data[3] && hi_bit !== word[0])
            edge_err <= 1'b1;
    end
endmodule

// *** verification/tb.sv ***
/*
 tb: self-checking bench for sac_core over AXI4-Lite and its pins.
 Assumes sac_host_model as the far side and the bound checker.
*/
`timescale 1ns/10ps
module tb
    import sac_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, convert_start_n, select_n, read_n, comparator, busy, low_power;
    logic ref_buffer_enable, comp_level, clear, edge_err;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [17:0] word;
    logic [4:0]  bits;
    sac_bus_t    dbus;
    int          failures, comparisons, cnt;

    sac_core uut (.*);
    sac_host_model host (.*);

    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_up(input int n);
        if (n >= 3000)
        begin
            failures++;
            tally_and_finish();
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        bit aw = 0, w = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 3000 && s_axi_bvalid !== 1'b1; n++)
        begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'b1)
            begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1)
            begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        give_up(n);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 3000 && s_axi_rvalid !== 1'b1; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        give_up(n);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed);
        check(32'(s_axi_rresp), 32'(er));
    endtask

    task automatic wait_busy(input logic lvl, output int c);
        for (c = 0; c < 3000 && busy !== lvl; c++)
            @(posedge aclk);
        give_up(c);
    endtask

    task automatic pulse_start();
        @(posedge aclk);
        convert_start_n <= 1'b0;
        repeat (4) @(posedge aclk);
        convert_start_n <= 1'b1;
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial
    begin
        failures = 0; comparisons = 0; aresetn = 1'b0; s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf; s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0; s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
        convert_start_n = 1'b1; select_n = 1'b1; read_n = 1'b1; comp_level = 1'b1;
        clear = 1'b1;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // register map and refusals
        axi_read(OFS_CTRL, 32'(CTRL_RESET), RESP_OKAY);
        axi_read(8'h10, 32'h0, RESP_SLVERR);
        axi_write(8'h10, 32'h3f, RESP_SLVERR);
        axi_read(OFS_CTRL, 32'(CTRL_RESET), RESP_OKAY);
        axi_write(OFS_CTRL, 32'h0c5, RESP_OKAY);
        repeat (3) @(posedge aclk);
        check(32'(ref_buffer_enable), 32'h0);
        axi_write(OFS_CTRL, 32'(CTRL_RESET), RESP_OKAY);
        repeat (3) @(posedge aclk);
        check(32'(ref_buffer_enable), 32'h1);
        // restart attempts ignored mid-conversion
        pulse_start();
        wait_busy(1'b1, cnt);
        fork
            wait_busy(1'b0, cnt);
            begin
                repeat (100) @(posedge aclk);
                axi_write(OFS_CTRL, 32'h0c3, RESP_OKAY);
                pulse_start();
            end
        join
        check(32'(cnt >= CONV_CYC - 2 && cnt <= CONV_CYC + 1), 32'h1);
        // held start keeps converting
        axi_write(OFS_CTRL, 32'(CTRL_RESET), RESP_OKAY);
        convert_start_n <= 1'b0;
        wait_busy(1'b1, cnt);
        select_n <= 1'b0;
        read_n <= 1'b0;
        repeat (6) @(posedge aclk);
        check(32'(dbus.data), 32'h3ffff);
        check(32'(dbus.data_oe), 32'h3ffff);
        read_n <= 1'b1;
        repeat (6) @(posedge aclk);
        check(32'(dbus.data_oe), 32'h0);
        wait_busy(1'b0, cnt);
        wait_busy(1'b1, cnt);
        check(32'(cnt >= ACQ_CYC - 2 && cnt <= ACQ_CYC + 4), 32'h1);
        convert_start_n <= 1'b1;
        wait_busy(1'b0, cnt);
        repeat (ACQ_CYC + 20) @(posedge aclk);
        wait_busy(1'b0, cnt);
        // master serial, read after conversion, twos complement
        comp_level <= 1'b0;
        read_n <= 1'b0;
        axi_write(OFS_CTRL, 32'h031, RESP_OKAY);
        clear <= 1'b0;
        pulse_start();
        wait_busy(1'b1, cnt);
        check(32'(dbus.data_oe[4:2]), 32'h7);
        wait_busy(1'b0, cnt);
        repeat (3) @(posedge aclk);
        check(32'(bits), 32'd18);
        check(32'(word), 32'h20000);
        check(32'(edge_err), 32'h0);
        axi_read(OFS_RESULT, 32'h20000, RESP_OKAY);
        axi_write(OFS_CTRL, 32'h421, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check(32'(dbus.data), 32'h80);
        tally_and_finish();
    end
endmodule
